//--- txom_pkg.sv
// Shared constants and types for the transmitter operating-mode control ends
package txom_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    TXOM_SLEEP    = 3'b000,
    TXOM_STANDBY  = 3'b001,
    TXOM_SYNTH    = 3'b010,
    TXOM_TRANSMIT = 3'b011
  } txom_mode_type;

  // Main clock
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Block wake-up times in microseconds, longest figures where given
  localparam int unsigned XO_WAKE_US = 500;
  localparam int unsigned SYNTH_WAKE_US = 150;
  localparam int unsigned PA_WAKE_US = 120;
  localparam int unsigned XO_WAKE_CYC = XO_WAKE_US * CLK_MHZ;
  localparam int unsigned SYNTH_WAKE_CYC = SYNTH_WAKE_US * CLK_MHZ;
  localparam int unsigned PA_WAKE_CYC = PA_WAKE_US * CLK_MHZ;

  // Button debounce time
  localparam int unsigned DEBOUNCE_US = 10000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned NUM_BUTTONS = 4;

  // Serial clock: each phase at least this long
  localparam int unsigned SCK_MIN_HALF_NS = 50;
  localparam int unsigned SCK_HALF_CYC = (SCK_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit clock half period in main clock cycles
  localparam int unsigned BIT_HALF_CYC = 125;

  // Slave write frame: write flag, 7-bit address, 8-bit data
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned FRAME_WRITE_POS = 15;
  localparam int unsigned FRAME_ADDR_MSB = 14;
  localparam int unsigned FRAME_ADDR_LSB = 8;
  localparam int unsigned MODE_MSB = 2;
  localparam logic [6:0] OPMODE_ADDR = 7'h01;
  localparam logic [4:0] OPMODE_PAD = 5'h00;

  // Serial memory: read command, 16-bit address field, 8 kbit of bytes
  localparam logic [7:0] E2_READ_CMD = 8'h03;
  localparam int unsigned E2_ADDR_BITS = 10;
  localparam int unsigned E2_PAGE_BITS = 6;
  localparam int unsigned E2_FRAME_BITS = 40;
  localparam int unsigned PAYLOAD_BITS = 8;

endpackage

//--- txom_if.sv
// Link between the transmitter device end and its controller end
`timescale 1ns/1ns
`default_nettype none

interface txom_if;
  logic por_rst;
  logic app_mode_select_pin;
  logic spi_sck;
  logic spi_nss_n;
  logic spi_mosi;
  logic data_pin;
  logic oscillator_clock_output;
  logic bit_clock_output;

  modport dev (
    input por_rst,
    input app_mode_select_pin,
    input spi_sck,
    input spi_nss_n,
    input spi_mosi,
    input data_pin,
    output oscillator_clock_output,
    output bit_clock_output
  );

  modport ctrl (
    output por_rst,
    output app_mode_select_pin,
    output spi_sck,
    output spi_nss_n,
    output spi_mosi,
    output data_pin,
    input oscillator_clock_output,
    input bit_clock_output
  );
endinterface

`default_nettype wire

//--- txom_ctrl.sv
// Controller end: drives reset, strap and mode writes; feeds data on the bit clock
`timescale 1ns/1ns
`default_nettype none

module txom_ctrl #(
  parameter int unsigned SCK_HALF = txom_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link
  txom_if.ctrl link,
  // User side
  input wire logic reset_req,
  input wire logic standalone_strap,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_mode,
  output logic cmd_ready,
  input wire logic data_bit,
  output logic data_taken
);
  import txom_pkg::*;

  typedef enum logic [1:0] {
    TXOM_C_IDLE  = 2'b00,
    TXOM_C_SHIFT = 2'b01,
    TXOM_C_HOLD  = 2'b10,
    TXOM_C_GAP   = 2'b11
  } txom_cstate_type;

  localparam int unsigned HW = $clog2(SCK_HALF + 1);

  if (SCK_HALF < SCK_HALF_CYC) begin : g_chk
    $error("SCK_HALF too short for the serial clock limits");
  end

  txom_cstate_type st_q;
  logic [HW-1:0] half_q;
  logic [4:0] bits_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic sck_q, nss_n_q, mosi_q, ready_q, por_q, strap_q, data_q, taken_q;
  logic bclk_s1, bclk_s2, bclk_s3;
  logic tick;

  assign tick = (half_q == HW'(SCK_HALF - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      por_q <= 1'b1;
      strap_q <= 1'b0;
    end else if (ce) begin
      por_q <= reset_req;
      strap_q <= standalone_strap;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= TXOM_C_IDLE;
      half_q <= '0;
      bits_q <= '0;
      sh_q <= '0;
      sck_q <= 1'b0;
      nss_n_q <= 1'b1;
      mosi_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (ce) begin
      half_q <= (st_q == TXOM_C_IDLE || tick) ? '0 : HW'(half_q + 1'b1);
      unique case (st_q)
        TXOM_C_IDLE: begin
          ready_q <= 1'b1;
          if (cmd_valid && ready_q) begin
            sh_q <= {1'b1, OPMODE_ADDR, OPMODE_PAD, cmd_mode};
            mosi_q <= 1'b1;
            nss_n_q <= 1'b0;
            bits_q <= 5'(FRAME_BITS);
            ready_q <= 1'b0;
            st_q <= TXOM_C_SHIFT;
          end
        end
        TXOM_C_SHIFT: if (tick) begin
          sck_q <= ~sck_q;
          if (!sck_q) begin
            bits_q <= bits_q - 5'h01;
          end else if (bits_q == 5'h00) begin
            st_q <= TXOM_C_HOLD;
          end else begin
            sh_q <= {sh_q[FRAME_BITS-2:0], 1'b0};
            mosi_q <= sh_q[FRAME_BITS-2];
          end
        end
        TXOM_C_HOLD: if (tick) begin
          nss_n_q <= 1'b1;
          st_q <= TXOM_C_GAP;
        end
        TXOM_C_GAP: if (tick) begin
          st_q <= TXOM_C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      bclk_s1 <= link.bit_clock_output;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
    end
  end

  // Change data on the falling edge so the device's rising edge sees it settled
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= 1'b0;
      taken_q <= 1'b0;
    end else if (ce) begin
      taken_q <= bclk_s3 & ~bclk_s2;
      if (bclk_s3 && !bclk_s2) begin
        data_q <= data_bit;
      end
    end
  end

  assign link.por_rst = por_q;
  assign link.app_mode_select_pin = strap_q;
  assign link.spi_sck = sck_q;
  assign link.spi_nss_n = nss_n_q;
  assign link.spi_mosi = mosi_q;
  assign link.data_pin = data_q;
  assign cmd_ready = ready_q;
  assign data_taken = taken_q;

endmodule // txom_ctrl

`default_nettype wire

//--- txom_device.sv
// Device end: operating-mode sequencer, slave mode port and stand-alone memory fetch
`timescale 1ns/1ns
`default_nettype none

module txom_device #(
  parameter int unsigned XO_WAKE = txom_pkg::XO_WAKE_CYC,
  parameter int unsigned SYNTH_WAKE = txom_pkg::SYNTH_WAKE_CYC,
  parameter int unsigned PA_WAKE = txom_pkg::PA_WAKE_CYC,
  parameter int unsigned DEBOUNCE = txom_pkg::DEBOUNCE_CYC,
  parameter int unsigned BIT_HALF = txom_pkg::BIT_HALF_CYC,
  parameter int unsigned E2_HALF = txom_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link
  txom_if.dev link,
  // Stand-alone pins
  input wire logic [txom_pkg::NUM_BUTTONS-1:0] button,
  input wire logic e2_miso,
  output logic e2_sck,
  output logic e2_cs_n,
  output logic e2_mosi,
  // Power state
  output txom_pkg::txom_mode_type mode_state,
  output logic xtal_en,
  output logic synth_en,
  output logic pa_en,
  output logic standalone,
  output logic tx_bit
);
  import txom_pkg::*;

  typedef enum logic [1:0] {
    TXOM_SA_IDLE  = 2'b00,
    TXOM_SA_FETCH = 2'b01,
    TXOM_SA_SEND  = 2'b10
  } txom_sastate_type;

  localparam int unsigned DW = $clog2(DEBOUNCE + 1);
  localparam int unsigned EW = $clog2(E2_HALF + 1);
  localparam int unsigned BW = $clog2(BIT_HALF + 1);

  // Memory reply sampling needs the synchroniser delay inside a half period
  if (E2_HALF < 4 || BIT_HALF < 4 || DEBOUNCE < 2 || XO_WAKE < 1 || SYNTH_WAKE < 1 ||
      PA_WAKE < 1) begin : g_chk
    $error("txom_device parameter out of range");
  end

  function automatic logic [31:0] wake_cyc(input txom_mode_type m);
    unique case (m)
      TXOM_STANDBY: wake_cyc = 32'(XO_WAKE);
      TXOM_SYNTH: wake_cyc = 32'(SYNTH_WAKE);
      TXOM_TRANSMIT: wake_cyc = 32'(PA_WAKE);
      default: wake_cyc = 32'h0000_0001;
    endcase
  endfunction

  function automatic logic mode_ok(input logic [7:0] v);
    mode_ok = (v[7:MODE_MSB+1] == '0) && (v[MODE_MSB:0] <= TXOM_TRANSMIT);
  endfunction

  // Link-clock domain: capture the frame shifted in
  logic [FRAME_BITS-1:0] rx_q;

  always_ff @(posedge link.spi_sck) begin
    if (!link.spi_nss_n) begin
      rx_q <= {rx_q[FRAME_BITS-2:0], link.spi_mosi};
    end
  end

  // Synchronisers; the frame word is read only after the end of frame crosses
  logic nss_s1, nss_s2, nss_s3, por_s1, por_s2, app_s1, app_s2, dat_s1, dat_s2;
  logic miso_s1, miso_s2;
  logic [NUM_BUTTONS-1:0] btn_s1, btn_s2;

  always_ff @(posedge clk) begin
    if (ce) begin
      nss_s1 <= link.spi_nss_n;
      nss_s2 <= nss_s1;
      nss_s3 <= nss_s2;
      por_s1 <= link.por_rst;
      por_s2 <= por_s1;
      app_s1 <= link.app_mode_select_pin;
      app_s2 <= app_s1;
      dat_s1 <= link.data_pin;
      dat_s2 <= dat_s1;
      miso_s1 <= e2_miso;
      miso_s2 <= miso_s1;
      btn_s1 <= button;
      btn_s2 <= btn_s1;
    end
  end

  logic reset;
  assign reset = rst | por_s2;

  logic sampled_q, sa_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sampled_q <= 1'b0;
      sa_q <= 1'b0;
    end else if (ce && !sampled_q) begin
      sampled_q <= 1'b1;
      sa_q <= app_s2;
    end
  end

  logic [DW-1:0] deb_cnt_q [NUM_BUTTONS];
  logic [NUM_BUTTONS-1:0] deb_q, combo_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      deb_q <= '0;
      for (int i = 0; i < NUM_BUTTONS; i++) begin
        deb_cnt_q[i] <= '0;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_BUTTONS; i++) begin
        if (btn_s2[i] == deb_q[i]) begin
          deb_cnt_q[i] <= '0;
        end else if (deb_cnt_q[i] == DW'(DEBOUNCE - 1)) begin
          deb_cnt_q[i] <= '0;
          deb_q[i] <= btn_s2[i];
        end else begin
          deb_cnt_q[i] <= DW'(deb_cnt_q[i] + 1'b1);
        end
      end
    end
  end

  // Gathers a combination; it fires when every button is released
  txom_sastate_type sa_st_q;
  txom_mode_type cur_q, target_q;
  logic trigger, frame_end, fetch_done, send_done, e2_tick, bit_rise;

  assign trigger = sa_q && (deb_q == '0) && (combo_q != '0) && (sa_st_q == TXOM_SA_IDLE) &&
                   (cur_q == TXOM_SLEEP);

  always_ff @(posedge clk) begin
    if (reset) begin
      combo_q <= '0;
    end else if (ce) begin
      combo_q <= (deb_q == '0) ? '0 : (combo_q | deb_q);
    end
  end

  // Memory read engine
  logic [EW-1:0] e2_cnt_q;
  logic [5:0] e2_bits_q;
  logic [E2_FRAME_BITS-1:0] e2_tx_q;
  logic [FRAME_BITS-1:0] e2_rx_q;
  logic e2_sck_q, e2_cs_n_q, e2_mosi_q;

  assign e2_tick = (e2_cnt_q == EW'(E2_HALF - 1));
  assign fetch_done = (sa_st_q == TXOM_SA_FETCH) && e2_tick && e2_sck_q && (e2_bits_q == '0);

  // Master fetch of settings and payload
  always_ff @(posedge clk) begin
    if (reset) begin
      e2_cnt_q <= '0;
      e2_bits_q <= '0;
      e2_tx_q <= '0;
      e2_rx_q <= '0;
      e2_sck_q <= 1'b0;
      e2_cs_n_q <= 1'b1;
      e2_mosi_q <= 1'b0;
    end else if (ce) begin
      if (trigger) begin
        e2_tx_q <= {E2_READ_CMD, (16 - E2_ADDR_BITS)'(0), combo_q, E2_PAGE_BITS'(0),
                    FRAME_BITS'(0)};
        e2_mosi_q <= E2_READ_CMD[7];
        e2_cs_n_q <= 1'b0;
        e2_bits_q <= 6'(E2_FRAME_BITS);
        e2_cnt_q <= '0;
      end else if (sa_st_q == TXOM_SA_FETCH) begin
        e2_cnt_q <= e2_tick ? '0 : EW'(e2_cnt_q + 1'b1);
        if (e2_tick) begin
          e2_sck_q <= ~e2_sck_q;
          if (!e2_sck_q) begin
            e2_rx_q <= {e2_rx_q[FRAME_BITS-2:0], miso_s2};
            e2_bits_q <= e2_bits_q - 6'h01;
          end else if (e2_bits_q == '0) begin
            e2_cs_n_q <= 1'b1;
          end else begin
            e2_tx_q <= {e2_tx_q[E2_FRAME_BITS-2:0], 1'b0};
            e2_mosi_q <= e2_tx_q[E2_FRAME_BITS-2];
          end
        end
      end
    end
  end

  // Transmit bit clock and payload
  logic [BW-1:0] bit_cnt_q;
  logic bit_clk_q, tx_bit_q;
  logic [PAYLOAD_BITS-1:0] pay_q;
  logic [3:0] pay_left_q;

  assign bit_rise = (cur_q == TXOM_TRANSMIT) && (bit_cnt_q == BW'(BIT_HALF - 1)) && !bit_clk_q;
  assign send_done = (sa_st_q == TXOM_SA_SEND) && bit_rise && (pay_left_q == 4'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_q <= '0;
      bit_clk_q <= 1'b0;
      tx_bit_q <= 1'b0;
      pay_q <= '0;
      pay_left_q <= '0;
    end else if (ce) begin
      if (cur_q != TXOM_TRANSMIT) begin
        bit_cnt_q <= '0;
        bit_clk_q <= 1'b0;
      end else if (bit_cnt_q == BW'(BIT_HALF - 1)) begin
        bit_cnt_q <= '0;
        bit_clk_q <= ~bit_clk_q;
      end else begin
        bit_cnt_q <= BW'(bit_cnt_q + 1'b1);
      end
      if (fetch_done) begin
        pay_q <= e2_rx_q[PAYLOAD_BITS-1:0];
        pay_left_q <= 4'(PAYLOAD_BITS);
      end else if (bit_rise) begin
        tx_bit_q <= sa_q ? pay_q[PAYLOAD_BITS-1] : dat_s2;
        if (sa_st_q == TXOM_SA_SEND) begin
          pay_q <= {pay_q[PAYLOAD_BITS-2:0], 1'b0};
          pay_left_q <= pay_left_q - 4'h1;
        end
      end
    end
  end

  // Stand-alone sequence and requested mode
  logic [7:0] cfg_byte;
  logic wr_mode;

  assign cfg_byte = e2_rx_q[FRAME_BITS-1:PAYLOAD_BITS];
  assign frame_end = nss_s2 && !nss_s3;
  assign wr_mode = !sa_q && frame_end && rx_q[FRAME_WRITE_POS] &&
                   (rx_q[FRAME_ADDR_MSB:FRAME_ADDR_LSB] == OPMODE_ADDR) &&
                   mode_ok(rx_q[PAYLOAD_BITS-1:0]);

  // Configure, then transmit and back to sleep only for a transmit setting
  always_ff @(posedge clk) begin
    if (reset) begin
      sa_st_q <= TXOM_SA_IDLE;
      target_q <= TXOM_SLEEP;
    end else if (ce) begin
      if (wr_mode) begin
        target_q <= txom_mode_type'(rx_q[MODE_MSB:0]);
      end
      unique case (sa_st_q)
        TXOM_SA_IDLE: if (trigger) begin
          sa_st_q <= TXOM_SA_FETCH;
        end
        TXOM_SA_FETCH: if (fetch_done) begin
          if (mode_ok(cfg_byte)) begin
            target_q <= txom_mode_type'(cfg_byte[MODE_MSB:0]);
          end
          sa_st_q <= (mode_ok(cfg_byte) && cfg_byte[MODE_MSB:0] == TXOM_TRANSMIT) ?
                     TXOM_SA_SEND : TXOM_SA_IDLE;
        end
        TXOM_SA_SEND: if (send_done) begin
          target_q <= TXOM_SLEEP;
          sa_st_q <= TXOM_SA_IDLE;
        end
        default: sa_st_q <= TXOM_SA_IDLE;
      endcase
    end
  end

  // Mode sequencer
  logic [31:0] wake_q;
  txom_mode_type next_mode, pwr_mode;
  logic xtal_q, synth_q, pa_q, osc_q;

  assign next_mode = txom_mode_type'(3'(cur_q + 3'h1));
  assign pwr_mode = (target_q > cur_q) ? next_mode : target_q;

  // One step at a time upward
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_q <= TXOM_SLEEP;
      wake_q <= '0;
    end else if (ce) begin
      if (target_q < cur_q) begin
        cur_q <= target_q;
        wake_q <= '0;
      end else if (target_q > cur_q) begin
        if (wake_q == wake_cyc(next_mode) - 32'h1) begin
          cur_q <= next_mode;
          wake_q <= '0;
        end else begin
          wake_q <= wake_q + 32'h1;
        end
      end
    end
  end

  // Blocks are powered for the mode being woken, not only the one reached
  // Oscillator out in slave mode
  always_ff @(posedge clk) begin
    if (reset) begin
      xtal_q <= 1'b0;
      synth_q <= 1'b0;
      pa_q <= 1'b0;
      osc_q <= 1'b0;
    end else if (ce) begin
      xtal_q <= (pwr_mode >= TXOM_STANDBY);
      synth_q <= (pwr_mode >= TXOM_SYNTH);
      pa_q <= (pwr_mode == TXOM_TRANSMIT);
      osc_q <= (!sa_q && xtal_q) ? ~osc_q : 1'b0;
    end
  end

  assign link.oscillator_clock_output = osc_q;
  assign link.bit_clock_output = bit_clk_q;
  assign e2_sck = e2_sck_q;
  assign e2_cs_n = e2_cs_n_q;
  assign e2_mosi = e2_mosi_q;
  assign mode_state = cur_q;
  assign xtal_en = xtal_q;
  assign synth_en = synth_q;
  assign pa_en = pa_q;
  assign standalone = sa_q;
  assign tx_bit = tx_bit_q;

endmodule // txom_device

`default_nettype wire

//--- txom_pkg_note_placeholder.sv
// Intentionally empty compile unit kept minimal
`timescale 1ns/1ns

//--- txom_properties.sv
// Link-wire checks for the operating-mode control ends
`timescale 1ns/1ns
`default_nettype none
module txom_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link wires
  input wire logic por_rst,
  input wire logic app_mode_select_pin,
  input wire logic spi_sck,
  input wire logic spi_nss_n,
  input wire logic spi_mosi,
  input wire logic data_pin,
  input wire logic oscillator_clock_output,
  input wire logic bit_clock_output
);
  import txom_pkg::*;
  logic sck_q;
  logic [4:0] bits_q;
  logic [15:0] frame_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    sck_q <= spi_sck;
  end
  // Frame rebuilt from the wires; count cleared between frames
  always_ff @(posedge clk) begin
    if (rst || spi_nss_n) begin
      bits_q <= 5'h00;
    end else if (spi_sck && !sck_q) begin
      bits_q <= bits_q + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (spi_sck && !sck_q) begin
      frame_q <= {frame_q[14:0], spi_mosi};
    end
  end
  sequence s_sck_low;
    !spi_sck [*8];
  endsequence
  sequence s_select_held;
    !spi_nss_n [*8];
  endsequence
  a_sck_idle_low: assert property (spi_nss_n |-> !spi_sck)
    else $error("serial clock active outside a frame");
  a_mosi_stable_high: assert property (spi_sck |-> $stable(spi_mosi))
    else $error("serial data moved while clock high");
  a_select_setup: assert property ($fell(spi_nss_n) |-> s_sck_low)
    else $error("clock rose too soon after select");
  a_select_hold: assert property ($fell(spi_sck) |-> s_select_held)
    else $error("select released too soon after clock");
  a_write_flag: assert property ($fell(spi_nss_n) |-> spi_mosi)
    else $error("frame does not open with write flag");
  a_frame_len: assert property ($rose(spi_nss_n) |-> bits_q == 5'h10)
    else $error("frame is not sixteen bits");
  a_frame_addr: assert property ($rose(spi_nss_n) |->
    frame_q[14:8] == OPMODE_ADDR && frame_q[7:3] == OPMODE_PAD)
    else $error("frame address or padding wrong");
  a_osc_half_rate: assert property ($rose(oscillator_clock_output) |=>
    !oscillator_clock_output)
    else $error("oscillator output not half rate");
  a_data_steady_bclk: assert property (bit_clock_output && $past(bit_clock_output)
    |-> $stable(data_pin))
    else $error("data pin moved while bit clock high");
  a_por_in_reset: assert property ($fell(rst) |-> por_rst)
    else $error("device reset not forced during reset");
  c_bit_clock: cover property ($rose(bit_clock_output));
endmodule // txom_properties
`default_nettype wire

//--- tb_top.sv
// Self-checking bench joining the controller end and the device end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import txom_pkg::*;
  localparam int SW = 15;
  localparam int PW = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reset_req = 1'b0;
  logic strap = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_mode = 3'h0;
  logic cmd_ready;
  logic data_bit = 1'b0;
  logic data_taken;
  logic [3:0] button = 4'h0;
  logic e2_miso = 1'b0;
  logic e2_sck;
  logic e2_cs_n;
  logic e2_mosi;
  txom_mode_type mode_state;
  logic xtal_en;
  logic synth_en;
  logic pa_en;
  logic standalone;
  logic tx_bit;
  logic bclk;
  int fails = 0;
  int samples_checked = 0;
  txom_if link();
  assign bclk = link.bit_clock_output;
  always #2 clk = ~clk;
  txom_ctrl #(.SCK_HALF(13)) i_txom_ctrl (.clk(clk), .rst(rst), .ce(ce), .link(link),
    .reset_req(reset_req), .standalone_strap(strap), .cmd_valid(cmd_valid),
    .cmd_mode(cmd_mode), .cmd_ready(cmd_ready), .data_bit(data_bit), .data_taken(data_taken));
  txom_device #(.XO_WAKE(40), .SYNTH_WAKE(SW), .PA_WAKE(PW), .DEBOUNCE(8), .BIT_HALF(8),
    .E2_HALF(4)) i_txom_device (.clk(clk), .rst(rst), .ce(ce), .link(link), .button(button),
    .e2_miso(e2_miso), .e2_sck(e2_sck), .e2_cs_n(e2_cs_n), .e2_mosi(e2_mosi),
    .mode_state(mode_state), .xtal_en(xtal_en), .synth_en(synth_en), .pa_en(pa_en),
    .standalone(standalone), .tx_bit(tx_bit));
  txom_properties i_txom_properties (.clk(clk), .rst(rst), .por_rst(link.por_rst),
    .app_mode_select_pin(link.app_mode_select_pin), .spi_sck(link.spi_sck),
    .spi_nss_n(link.spi_nss_n), .spi_mosi(link.spi_mosi), .data_pin(link.data_pin),
    .oscillator_clock_output(link.oscillator_clock_output), .bit_clock_output(bclk));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Inputs move 1 ns after the edge, outputs read once settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_lv(ref logic s, input logic v, input string what);
    for (int i = 0; i < 3000 && s !== v; i++) begin
      tick(1);
    end
    if (s !== v) begin
      chk(what, 8'(v), 8'(s));
      close_out();
    end
  endtask
  task automatic wait_mode(input txom_mode_type m);
    for (int i = 0; i < 3000 && mode_state !== m; i++) begin
      tick(1);
    end
    if (mode_state !== m) begin
      chk("mode wait", 8'(m), 8'(mode_state));
      close_out();
    end
  endtask
  task automatic send_mode(input logic [2:0] m);
    wait_lv(cmd_ready, 1'b1, "ready");
    cmd_valid <= 1'b1;
    cmd_mode <= m;
    tick(1);
    cmd_valid <= 1'b0;
    wait_lv(cmd_ready, 1'b1, "ready");
    tick(8);
  endtask
  task automatic t_reset();
    chk("reset mode", 8'h00, 8'(mode_state));
    chk("reset select", 8'h01, 8'(e2_cs_n));
    chk("strap low", 8'h00, 8'(standalone));
    $display("test reset done");
  endtask
  task automatic t_climb();
    int n1 = 0;
    int n2 = 0;
    int bad = 0;
    logic [2:0] prev = 3'h0;
    logic osc;
    send_mode(3'h3);
    for (int i = 0; i < 3000 && mode_state !== TXOM_TRANSMIT; i++) begin
      tick(1);
      if (mode_state !== prev && 3'(mode_state) !== prev + 3'h1) bad++;
      if (mode_state === TXOM_STANDBY) n1++;
      if (mode_state === TXOM_SYNTH) n2++;
      prev = 3'(mode_state);
    end
    chk("step order", 8'h00, 8'(bad));
    chk("standby dwell", 8'h01, 8'(n1 >= SW));
    chk("synth dwell", 8'h01, 8'(n2 >= PW));
    chk("top mode", 8'h03, 8'(mode_state));
    chk("xtal on", 8'h01, 8'(xtal_en));
    chk("synth on", 8'h01, 8'(synth_en));
    chk("pa on", 8'h01, 8'(pa_en));
    osc = link.oscillator_clock_output;
    tick(1);
    chk("osc toggles", 8'h01, 8'(osc ^ link.oscillator_clock_output));
    $display("test climb done");
  endtask
  task automatic t_data();
    int nt = 0;
    data_bit <= 1'b1;
    // Bit period is 16 cycles here, so about four hand-overs
    for (int i = 0; i < 64; i++) begin
      tick(1);
      if (data_taken === 1'b1) nt++;
    end
    chk("data taken", 8'h01, 8'(nt >= 3));
    chk("tx bit high", 8'h01, 8'(tx_bit));
    data_bit <= 1'b0;
    tick(64);
    chk("tx bit low", 8'h00, 8'(tx_bit));
    $display("test data done");
  endtask
  task automatic t_codes();
    send_mode(3'h0);
    chk("down mode", 8'h00, 8'(mode_state));
    chk("down pa", 8'h00, 8'(pa_en));
    send_mode(3'h5);
    tick(60);
    chk("bad code", 8'h00, 8'(mode_state));
    for (int m = 1; m < 3; m++) begin
      send_mode(3'(m));
      wait_mode(txom_mode_type'(m));
      tick(60);
      chk("held mode", 8'(m), 8'(mode_state));
      send_mode(3'h0);
    end
    $display("test codes done");
  endtask
  task automatic t_strap();
    strap <= 1'b1;
    tick(50);
    chk("strap ignored", 8'h00, 8'(standalone));
    reset_req <= 1'b1;
    tick(6);
    reset_req <= 1'b0;
    tick(12);
    chk("strap resampled", 8'h01, 8'(standalone));
    $display("test strap done");
  endtask
  task automatic t_alone();
    logic [39:0] cap = '0;
    logic [39:0] rd = {24'h0, 8'h03, 8'hA5};
    logic [7:0] pay = '0;
    send_mode(3'h3);
    chk("write refused", 8'h00, 8'(mode_state));
    button <= 4'h5;
    tick(3);
    button <= 4'h0;
    tick(30);
    chk("glitch ignored", 8'h01, 8'(e2_cs_n));
    button <= 4'h5;
    tick(30);
    button <= 4'h0;
    wait_lv(e2_cs_n, 1'b0, "fetch start");
    for (int k = 0; k < 40; k++) begin
      wait_lv(e2_sck, 1'b1, "mem clock");
      cap = {cap[38:0], e2_mosi};
      wait_lv(e2_sck, 1'b0, "mem clock");
      if (k < 39) e2_miso <= rd[38-k];
    end
    wait_lv(e2_cs_n, 1'b1, "fetch end");
    e2_miso <= ~e2_miso;
    chk("mem command", 8'h03, cap[39:32]);
    chk("mem addr high", 8'h01, cap[31:24]);
    chk("mem addr low", 8'h40, cap[23:16]);
    wait_mode(TXOM_TRANSMIT);
    for (int k = 0; k < 8; k++) begin
      wait_lv(bclk, 1'b0, "bit clock");
      wait_lv(bclk, 1'b1, "bit clock");
      tick(2);
      pay = {pay[6:0], tx_bit};
    end
    chk("payload", 8'hA5, pay);
    wait_mode(TXOM_SLEEP);
    chk("back to sleep", 8'h00, 8'(mode_state));
    $display("test stand-alone done");
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(5);
    t_reset();
    t_climb();
    t_data();
    t_codes();
    t_strap();
    t_alone();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
